// ===== inc/ccv_pkg.sv
package ccv_pkg;

  // Register addresses on the register-bank access port.
  localparam logic [7:0] CTL3_ADDR = 8'h13;
  localparam logic [7:0] CTL4_ADDR = 8'h14;
  localparam logic [7:0] CTL5_ADDR = 8'h15;

  // Field positions.
  localparam int PRE_MSB = 5;
  localparam int PRE_TRIM_LSB = 3;
  localparam int PRE_TRIM_MSB = 4;
  localparam int DEAD_TIMER_LSB = 6;
  localparam int DEAD_TIMER_MSB = 7;
  localparam int DEAD_MSB = 5;
  localparam int DEAD_TRIM_LO = 2;
  localparam int DEAD_TRIM_HI = 4;
  localparam int RESTART_BIT = 6;
  localparam int VREG_MSB = 5;

  // Untrimmed reset values.
  localparam logic [7:0] CTL3_RST = 8'h08;
  localparam logic [7:0] CTL4_RST = 8'h04;
  localparam logic [7:0] CTL5_RST = 8'h1e;

  // Trim input values that reproduce the untrimmed defaults.
  localparam logic [1:0] PRE_TRIM_DEF = 2'h1;
  localparam logic [1:0] DEAD_TRIM_DEF = 2'h1;
  localparam logic RESTART_TRIM_DEF = 1'b0;
  localparam logic [5:0] VREG_TRIM_DEF = 6'h1e;

  // Dead-battery timer codes.
  localparam logic [1:0] DEAD_TIMER_5S = 2'h0;
  localparam logic [1:0] DEAD_TIMER_10S = 2'h1;
  localparam logic [1:0] DEAD_TIMER_20S = 2'h2;
  localparam logic [1:0] DEAD_TIMER_40S = 2'h3;

  // Highest regulation code; 4.60 V, codes above it saturate here.
  localparam logic [5:0] VREG_MAX_CODE = 6'h32;

  // Value returned for an unmapped read.
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

endpackage

// ===== src/ccv_regs.sv
`timescale 1ns/1ps
module ccv_regs #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic charger_config_lock_i,
  input wire logic [1:0] precharge_trim_i,
  input wire logic [1:0] dead_battery_trim_i,
  input wire logic recharge_trim_i,
  input wire logic [5:0] regulation_trim_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic rdata_valid_o,
  output logic [5:0] precharge_current_o,
  output logic [1:0] dead_battery_timer_o,
  output logic [5:0] dead_battery_current_o,
  output logic recharge_threshold_sel_o,
  output logic [5:0] regulation_code_o
);

  logic [DATA_W-1:0] ctl3_reg;
  logic [DATA_W-1:0] ctl4_reg;
  logic [DATA_W-1:0] ctl5_reg;
  logic [DATA_W-1:0] ctl3_rst;
  logic [DATA_W-1:0] ctl4_rst;
  logic [DATA_W-1:0] ctl5_rst;
  logic [DATA_W-1:0] rdata_next;
  logic [5:0] regulation_next;
  logic wr_ok;
  logic sel3;
  logic sel4;
  logic sel5;

  assign sel3 = (addr_i == ADDR_W'(ccv_pkg::CTL3_ADDR));
  assign sel4 = (addr_i == ADDR_W'(ccv_pkg::CTL4_ADDR));
  assign sel5 = (addr_i == ADDR_W'(ccv_pkg::CTL5_ADDR));

  assign wr_ok = wr_en_i && !charger_config_lock_i;

  // Trimmed reset images; reserved bits come from the all-zero upper bits.
  always_comb begin
    ctl3_rst = DATA_W'(ccv_pkg::CTL3_RST);
    ctl3_rst[ccv_pkg::PRE_TRIM_MSB:ccv_pkg::PRE_TRIM_LSB] = precharge_trim_i;
    ctl4_rst = DATA_W'(ccv_pkg::CTL4_RST);
    ctl4_rst[ccv_pkg::DEAD_TRIM_LO] = dead_battery_trim_i[0];
    ctl4_rst[ccv_pkg::DEAD_TRIM_HI] = dead_battery_trim_i[1];
    ctl5_rst = DATA_W'(ccv_pkg::CTL5_RST);
    ctl5_rst[ccv_pkg::RESTART_BIT] = recharge_trim_i;
    ctl5_rst[ccv_pkg::VREG_MSB:0] = regulation_trim_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctl3_reg <= ctl3_rst;
    end else if (wr_ok && sel3) begin
      ctl3_reg <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctl4_reg <= ctl4_rst;
    end else if (wr_ok && sel4) begin
      ctl4_reg <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ctl5_reg <= ctl5_rst;
    end else if (wr_ok && sel5) begin
      ctl5_reg <= wdata_i;
    end
  end

  always_comb begin
    rdata_next = DATA_W'(ccv_pkg::UNMAPPED_DATA);
    if (sel3) begin
      rdata_next = ctl3_reg;
    end else if (sel4) begin
      rdata_next = ctl4_reg;
    end else if (sel5) begin
      rdata_next = ctl5_reg;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= '0;
      rdata_valid_o <= 1'b0;
    end else begin
      rdata_valid_o <= rd_en_i;
      if (rd_en_i) begin
        rdata_o <= rdata_next;
      end
    end
  end

  always_comb begin
    regulation_next = ctl5_reg[ccv_pkg::VREG_MSB:0];
    if (regulation_next > ccv_pkg::VREG_MAX_CODE) begin
      regulation_next = ccv_pkg::VREG_MAX_CODE;
    end
  end

  // The voltage setpoint follows the stored field one cycle later.
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      regulation_code_o <= ccv_pkg::VREG_TRIM_DEF;
    end else begin
      regulation_code_o <= regulation_next;
    end
  end

  assign precharge_current_o = ctl3_reg[ccv_pkg::PRE_MSB:0];
  assign dead_battery_timer_o = ctl4_reg[ccv_pkg::DEAD_TIMER_MSB:ccv_pkg::DEAD_TIMER_LSB];
  assign dead_battery_current_o = ctl4_reg[ccv_pkg::DEAD_MSB:0];
  assign recharge_threshold_sel_o = ctl5_reg[ccv_pkg::RESTART_BIT];

  sequence s_wr(logic sel);
    wr_en_i && !charger_config_lock_i && sel;
  endsequence

  sequence s_locked_wr;
    wr_en_i && charger_config_lock_i && (sel3 || sel4 || sel5);
  endsequence

  sequence s_rd(logic sel);
    rd_en_i && !wr_en_i && sel;
  endsequence

  a_precharge_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> precharge_current_o[2:0] == 3'h0 && precharge_current_o[5] == 1'b0
      && precharge_current_o[4:3] == $past(precharge_trim_i))
    else $error("pre-charge reset value wrong");

  a_precharge_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_wr(sel3) |=> precharge_current_o == $past(wdata_i[5:0]))
    else $error("pre-charge field did not take written code");

  a_trim_choices: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> (precharge_current_o & 6'h27) == 6'h00)
    else $error("pre-charge reset outside 0/8/16/24 mA");

  a_ctl4_readback: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_wr(sel4) ##1 !wr_en_i ##1 s_rd(sel4) |=> rdata_valid_o
      && rdata_o == $past(wdata_i, 3))
    else $error("register 14h readback mismatch");

  a_timer_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> dead_battery_timer_o == ccv_pkg::DEAD_TIMER_5S)
    else $error("dead timer reset not 5 s");

  a_dead_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> dead_battery_current_o == {1'b0, $past(dead_battery_trim_i[1]),
      1'b0, $past(dead_battery_trim_i[0]), 2'h0})
    else $error("dead current reset value wrong");

  a_dead_write: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_wr(sel4) |=> dead_battery_current_o == $past(wdata_i[5:0])
      && dead_battery_timer_o == $past(wdata_i[7:6]))
    else $error("dead fields did not take written value");

  a_restart_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> recharge_threshold_sel_o == $past(recharge_trim_i))
    else $error("recharge threshold reset wrong");

  a_vreg_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ctl5_reg[5:0] == $past(regulation_trim_i))
    else $error("regulation reset wrong");

  a_vreg_saturate: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_wr(sel5) ##1 !(wr_en_i && sel5) |=> regulation_code_o ==
      (($past(wdata_i[5:0], 2) > 6'h32) ? 6'h32 : $past(wdata_i[5:0], 2)))
    else $error("regulation code not saturated");

  a_ctl3_read: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_en_i && sel3) |=> rdata_valid_o && rdata_o == $past(ctl3_reg))
    else $error("register 13h read mismatch");

  a_ctl5_read: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_rd(sel5) |=> rdata_valid_o && rdata_o == $past(ctl5_reg))
    else $error("register 15h read mismatch");

  a_valid_pulse: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    !rd_en_i |=> !rdata_valid_o)
    else $error("read valid without a read");

  a_lock_holds: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_locked_wr |=> $stable(ctl3_reg) && $stable(ctl4_reg) && $stable(ctl5_reg))
    else $error("locked register changed on write");

  a_locked_read: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_en_i && charger_config_lock_i && sel4) |=> rdata_valid_o
      && rdata_o == $past(ctl4_reg))
    else $error("read under lock mismatch");

  a_reserved_store: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_wr(sel5) |=> ctl5_reg[7] == $past(wdata_i[7]))
    else $error("reserved bit not stored");

  a_reserved_ctl3: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    s_wr(sel3) |=> ctl3_reg[7:6] == $past(wdata_i[7:6]))
    else $error("reserved bits of 13h not stored");

  a_reserved_reset: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    $fell(rst_i) |-> ctl3_reg[7:6] == 2'h0 && ctl5_reg[7] == 1'b0)
    else $error("reserved bits not cleared by reset");

  a_unmapped_zero: assert property (
    @(posedge ref_clk_i) disable iff (rst_i)
    (rd_en_i && !sel3 && !sel4 && !sel5) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");

endmodule

// ===== testbench/ccv_host.sv
`timescale 1ns/1ps
module ccv_host (
  input wire logic ref_clk_i,
  input wire logic rdata_valid_i,
  output logic wr_en_o,
  output logic rd_en_o,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o
);
  initial begin
    wr_en_o = 1'b0;
    rd_en_o = 1'b0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  // Released lines show the inverse of their last value.
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_en_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    wr_en_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic ok);
    @(posedge ref_clk_i);
    #1;
    addr_o = a;
    rd_en_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    rd_en_o = 1'b0;
    addr_o = ~a;
    ok = rdata_valid_i;
  endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic ref_clk_i, rst_i, we, re, lk, rt, rcv, rdv, ok;
  logic [7:0] a, d, rdata;
  logic [1:0] pt, dt, tim;
  logic [5:0] vt, pre, dead, vreg;
  int miscompares, checks;
  int m [3];
  // Constant-current code assumed for the rest of the bank; plain default.
  localparam logic [5:0] CC_SETTING = 6'h28;
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  ccv_host host (.ref_clk_i(ref_clk_i), .rdata_valid_i(rdv), .wr_en_o(we), .rd_en_o(re),
    .addr_o(a), .wdata_o(d));
  ccv_regs dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .wr_en_i(we), .rd_en_i(re),
    .addr_i(a), .wdata_i(d), .charger_config_lock_i(lk), .precharge_trim_i(pt),
    .dead_battery_trim_i(dt), .recharge_trim_i(rt), .regulation_trim_i(vt),
    .rdata_o(rdata), .rdata_valid_o(rdv), .precharge_current_o(pre),
    .dead_battery_timer_o(tim), .dead_battery_current_o(dead),
    .recharge_threshold_sel_o(rcv), .regulation_code_o(vreg));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input int n);
    @(posedge ref_clk_i);
    #1;
    rst_i = 1'b1;
    repeat (n) @(posedge ref_clk_i);
    #1;
    rst_i = 1'b0;
    m[0] = {pt, 3'h0};
    m[1] = {dt[1], 1'b0, dt[0], 2'h0};
    m[2] = {rt, vt};
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] dd);
    host.write(ad, dd);
    if (!lk && ad >= 8'h13 && ad <= 8'h15) m[ad - 8'h13] = dd;
  endtask
  task automatic rd(input logic [7:0] ad);
    host.read(ad, ok);
    chk({7'h0, ok}, 8'h01);
    if (ok !== 1'b1) results();
    else chk(rdata, (ad >= 8'h13 && ad <= 8'h15) ? 8'(m[ad - 8'h13]) : 8'h00);
  endtask
  task automatic outs();
    int v;
    @(posedge ref_clk_i);
    #1;
    v = m[2] & 'h3f;
    chk({2'h0, pre}, 8'(m[0] & 'h3f));
    chk({6'h0, tim}, 8'(m[1] >> 6));
    chk({2'h0, dead}, 8'(m[1] & 'h3f));
    chk({7'h0, rcv}, 8'((m[2] >> 6) & 1));
    chk({2'h0, vreg}, 8'((v > 'h32) ? 'h32 : v));
  endtask
  task automatic regs();
    for (int i = 0; i < 3; i++) begin
      rd(8'h13 + 8'(i));
    end
    outs();
  endtask
  initial begin
    logic [7:0] ra, rv;
    rst_i = 1'b1;
    lk = 1'b0;
    pt = ccv_pkg::PRE_TRIM_DEF;
    dt = ccv_pkg::DEAD_TRIM_DEF;
    rt = ccv_pkg::RESTART_TRIM_DEF;
    vt = ccv_pkg::VREG_TRIM_DEF;
    void'($urandom(55675));
    do_reset(20);
    regs();
    $display("test reset_default done");
    pt = 2'($urandom);
    dt = 2'($urandom);
    rt = 1'($urandom);
    vt = 6'($urandom);
    do_reset(2);
    regs();
    $display("test reset_trim done");
    repeat (24) begin
      ra = 8'h13 + 8'($urandom_range(2));
      rv = 8'($urandom);
      if (ra == 8'h13 && rv[5:0] > CC_SETTING) rv[5:0] = CC_SETTING;
      if (ra == 8'h13 && rv[5:0] < m[1][5:0]) rv[5:0] = m[1][5:0];
      if (ra == 8'h14 && rv[5:0] > m[0][5:0]) rv[5:0] = m[0][5:0];
      wr(ra, rv);
      rd(ra);
      outs();
    end
    $display("test random_rw done");
    for (int c = 'h30; c < 'h40; c++) begin
      wr(8'h15, 8'(c) | 8'h80);
      outs();
    end
    $display("test vreg_sat done");
    @(posedge ref_clk_i);
    #1;
    lk = 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(8'h13 + 8'(i), ~8'(m[i]));
    end
    regs();
    lk = 1'b0;
    $display("test lock done");
    rd(8'h12);
    rd(8'h16);
    $display("test unmapped done");
    results();
  end
endmodule
